/* rtl/low_power_pkg.sv */
// Purpose: shared constants of the low power sequencer
// Assumes: 16-bit register port, word offsets
// Notes:   fields are bit positions inside their registers
package low_power_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] CHIP_CONFIGURATION_ADDR = 4'h0;
   localparam logic [3:0] TX_CONTROL_ADDR         = 4'h1;
   localparam logic [3:0] RX_CONTROL_ADDR         = 4'h2;
   localparam logic [3:0] PHY_CONTROL_ADDR        = 4'h3;
   localparam logic [3:0] BUFFER_COMMAND_ADDR     = 4'h4;
   localparam logic [3:0] BUFFER_STATUS_ADDR      = 4'h5;
   localparam logic [3:0] POWER_STATUS_ADDR       = 4'h6;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CORE_POWER_ENABLE_BIT = 15;
   localparam int TX_PATH_ENABLE_BIT    = 0;
   localparam int RX_PATH_ENABLE_BIT    = 0;
   localparam int PHY_POWER_DOWN_BIT    = 11;
   localparam int PHY_ISOLATE_BIT       = 10;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CHIP_CONFIGURATION_RESET = 16'h8000;
   localparam logic [15:0] ZERO_WORD                = 16'h0000;
   // ----------------------------------------------------------------
   // buffer manager commands, low three bits of the command word
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP        = 3'h0,
      CMD_ALLOCATE   = 3'h1,
      CMD_RELEASE_TX = 3'h2,
      CMD_RELEASE_RX = 3'h3,
      CMD_RESET      = 3'h4
   } buffer_cmd_t;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_HZ            = 20_000_000;
   localparam int PHY_SETTLE_MS       = 500;
   localparam int PHY_SETTLE_CYCLES   = PHY_SETTLE_MS * (CLOCK_HZ / 1000);
   localparam int LINK_CLOCK_DIV      = 2;
endpackage : low_power_pkg

/* rtl/phy_power_if.sv */
// Purpose: control bundle between sequencer and phy power block
// Assumes: single clock
// Notes:   pulses are one cycle long
`timescale 1ns/100ps
interface phy_power_if;
   logic power_down;
   logic isolate_clear;
   logic isolate;
   logic settled;
   logic line_oe_n;
   modport ctrl (output power_down, output isolate_clear,
                 input isolate, input settled, input line_oe_n);
   modport phy  (input power_down, input isolate_clear,
                 output isolate, output settled, output line_oe_n);
endinterface : phy_power_if

/* rtl/clock_gate.sv */
// Purpose: divided clock with glitch-free gate
// Assumes: enable may change at any cycle
// Notes:   gate only moves while the divided level is low
`timescale 1ns/100ps
module clock_gate #(
   parameter int DIV = 2
) (
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   output logic      gated_clock_o,
   output logic      running_o
);
   logic [7:0] div_reg;
   logic       level_reg;
   logic       gate_reg;
   wire        tick = (div_reg == 8'(DIV - 1));
   wire        level_next = tick ? ~level_reg : level_reg;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         div_reg   <= 8'h00;
         level_reg <= 1'b0;
         gate_reg  <= 1'b1;
      end else begin
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
         if (tick) begin
            level_reg <= ~level_reg;
         end
         // the output follows the next level, so the gate may only move while that is low
         if (!level_next) begin
            gate_reg <= enable_i;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         gated_clock_o <= 1'b0;
      end else begin
         gated_clock_o <= level_next & gate_reg;
      end
   end

   assign running_o = gate_reg;
endmodule : clock_gate

/* rtl/phy_power.sv */
// Purpose: internal phy power-down and isolation state
// Assumes: settle count long, so a parameter
// Notes:   line outputs float while powered down
`timescale 1ns/100ps
module phy_power #(
   parameter int SETTLE_CYCLES = low_power_pkg::PHY_SETTLE_CYCLES
) (
   input  wire logic  clock_i,
   input  wire logic  reset_i,
   phy_power_if.phy   pwr
);
   logic [31:0] wait_reg;
   logic        down_reg;
   logic        iso_reg;
   logic        oe_n_reg;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         down_reg <= 1'b0;
         iso_reg  <= 1'b0;
         oe_n_reg <= 1'b0;
         wait_reg <= 32'h0000_0000;
      end else begin
         down_reg <= pwr.power_down;
         oe_n_reg <= pwr.power_down;
         if (down_reg && !pwr.power_down) begin
            iso_reg <= 1'b1;
         end else if (pwr.isolate_clear) begin
            iso_reg  <= 1'b0;
            wait_reg <= 32'(SETTLE_CYCLES);
         end
         if (pwr.power_down) begin
            wait_reg <= 32'h0000_0000;
         end else if (wait_reg != 32'h0000_0000 && !pwr.isolate_clear) begin
            wait_reg <= wait_reg - 32'h0000_0001;
         end
      end
   end

   assign pwr.isolate   = iso_reg;
   assign pwr.line_oe_n = oe_n_reg;
   assign pwr.settled   = !down_reg && !iso_reg && (wait_reg == 32'h0000_0000);
endmodule : phy_power

/* rtl/low_power_sequencer.sv */
// Purpose: low power sequencing of mac core, phy and buffers
// Assumes: host port and frame signals on clock_i
// Notes:   clocks are divided levels, gated without glitches
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module low_power_sequencer #(
   parameter int PKT_COUNT     = 16,
   parameter int SETTLE_CYCLES = low_power_pkg::PHY_SETTLE_CYCLES,
   parameter int CLOCK_DIV     = low_power_pkg::LINK_CLOCK_DIV
) (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        write_i,
   input  wire logic        read_i,
   output logic      [15:0] rdata_o,
   input  wire logic        tx_pending_i,
   input  wire logic        tx_done_i,
   input  wire logic        rx_start_i,
   input  wire logic        rx_end_i,
   output logic             tx_active_o,
   output logic             rx_active_o,
   output logic             rx_store_o,
   output logic             mac_core_clock_o,
   output logic             rx_clock_o,
   output logic             tx_clock_o,
   output logic             line_oe_n_o
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   localparam int CW = $clog2(PKT_COUNT + 1);

   logic [15:0]  chip_configuration_reg;
   logic         tx_path_enable_reg;
   logic         rx_path_enable_reg;
   logic         phy_power_down_reg;
   logic         isolate_clear_reg;
   logic [CW-1:0] in_use_reg;
   logic [CW-1:0] tx_done_q_reg;
   logic [CW-1:0] rx_q_reg;
   logic         tx_active_reg;
   logic         rx_active_reg;
   logic         rx_store_reg;
   logic [15:0]  rdata_reg;
   logic [2:0]   clocks_running;

   phy_power_if pwr ();

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire wr_config  = write_i && (addr_i == low_power_pkg::CHIP_CONFIGURATION_ADDR);
   wire wr_tx      = write_i && (addr_i == low_power_pkg::TX_CONTROL_ADDR);
   wire wr_rx      = write_i && (addr_i == low_power_pkg::RX_CONTROL_ADDR);
   wire wr_phy     = write_i && (addr_i == low_power_pkg::PHY_CONTROL_ADDR);
   wire wr_command = write_i && (addr_i == low_power_pkg::BUFFER_COMMAND_ADDR);

   wire core_power_enable = chip_configuration_reg[low_power_pkg::CORE_POWER_ENABLE_BIT];

   wire [2:0] command = wr_command ? wdata_i[2:0] : 3'h0;
   wire cmd_alloc  = (command == low_power_pkg::CMD_ALLOCATE);
   wire cmd_rel_tx = (command == low_power_pkg::CMD_RELEASE_TX);
   wire cmd_rel_rx = (command == low_power_pkg::CMD_RELEASE_RX);
   wire cmd_reset  = (command == low_power_pkg::CMD_RESET);

   // mac logic only moves while its core clock runs
   wire core_live  = clocks_running[0];
   wire tx_start   = core_live && tx_path_enable_reg && tx_pending_i
                     && !tx_active_reg;
   wire tx_finish  = core_live && tx_active_reg && tx_done_i;
   wire rx_accept  = core_live && rx_path_enable_reg && rx_start_i
                     && !rx_active_reg && (in_use_reg < CW'(PKT_COUNT));
   wire rx_finish  = core_live && rx_active_reg && rx_end_i;

   wire tx_q_empty = (tx_done_q_reg == '0);
   wire rx_q_empty = (rx_q_reg == '0);
   wire all_free   = (in_use_reg == '0) && tx_q_empty && rx_q_empty;
   wire low_power  = !core_power_enable && !clocks_running[0];

   // ----------------------------------------------------------------
   // host-written controls
   // ----------------------------------------------------------------
   // the port never looks at core power, so it works in low power
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         chip_configuration_reg <= low_power_pkg::CHIP_CONFIGURATION_RESET;
         tx_path_enable_reg     <= 1'b0;
         rx_path_enable_reg     <= 1'b0;
         phy_power_down_reg     <= 1'b0;
      end else begin
         if (wr_config) begin
            chip_configuration_reg <= wdata_i;
         end
         if (wr_tx) begin
            tx_path_enable_reg <= wdata_i[low_power_pkg::TX_PATH_ENABLE_BIT];
         end
         if (wr_rx) begin
            rx_path_enable_reg <= wdata_i[low_power_pkg::RX_PATH_ENABLE_BIT];
         end
         if (wr_phy) begin
            phy_power_down_reg <= wdata_i[low_power_pkg::PHY_POWER_DOWN_BIT];
         end
      end
   end

   // writing zero to the isolate bit clears it; one is ignored
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         isolate_clear_reg <= 1'b0;
      end else begin
         isolate_clear_reg <= wr_phy && pwr.isolate
                              && !wdata_i[low_power_pkg::PHY_ISOLATE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // transmit and receive frame tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         tx_active_reg <= 1'b0;
         rx_active_reg <= 1'b0;
         rx_store_reg  <= 1'b0;
      end else begin
         // a frame already on the wire runs to its end
         if (tx_start) begin
            tx_active_reg <= 1'b1;
         end else if (tx_finish) begin
            tx_active_reg <= 1'b0;
         end
         if (rx_accept) begin
            rx_active_reg <= 1'b1;
         end else if (rx_finish) begin
            rx_active_reg <= 1'b0;
         end
         rx_store_reg <= rx_finish;
      end
   end

   // ----------------------------------------------------------------
   // buffer manager accounting
   // ----------------------------------------------------------------
   // release of an empty queue is ignored rather than wrapping
   wire rel_tx_ok = cmd_rel_tx && !tx_q_empty && (in_use_reg != '0);
   wire rel_rx_ok = cmd_rel_rx && !rx_q_empty && (in_use_reg != '0);
   wire alloc_ok  = cmd_alloc && (in_use_reg < CW'(PKT_COUNT));

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         in_use_reg    <= '0;
         tx_done_q_reg <= '0;
         rx_q_reg      <= '0;
      end else if (cmd_reset) begin
         in_use_reg    <= '0;
         tx_done_q_reg <= '0;
         rx_q_reg      <= '0;
      end else begin
         in_use_reg <= in_use_reg + CW'(alloc_ok) + CW'(rx_accept)
                       - CW'(rel_tx_ok) - CW'(rel_rx_ok);
         tx_done_q_reg <= tx_done_q_reg + CW'(tx_finish) - CW'(rel_tx_ok);
         rx_q_reg      <= rx_q_reg + CW'(rx_finish) - CW'(rel_rx_ok);
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   wire [15:0] tx_word  = {15'h0000, tx_path_enable_reg};
   wire [15:0] rx_word  = {15'h0000, rx_path_enable_reg};
   wire [15:0] phy_word = {4'h0, phy_power_down_reg, pwr.isolate, 10'h000};
   wire [15:0] buf_word = {3'h0, all_free, rx_q_empty, tx_q_empty,
                           10'(in_use_reg)};
   wire [15:0] pwr_word = {8'h00, pwr.settled, pwr.isolate, !pwr.line_oe_n,
                           low_power, clocks_running, tx_active_reg};

   logic [15:0] rdata_next;
   always_comb begin
      case (addr_i)
         low_power_pkg::CHIP_CONFIGURATION_ADDR: rdata_next = chip_configuration_reg;
         low_power_pkg::TX_CONTROL_ADDR:         rdata_next = tx_word;
         low_power_pkg::RX_CONTROL_ADDR:         rdata_next = rx_word;
         low_power_pkg::PHY_CONTROL_ADDR:        rdata_next = phy_word;
         low_power_pkg::BUFFER_STATUS_ADDR:      rdata_next = buf_word;
         low_power_pkg::POWER_STATUS_ADDR:       rdata_next = pwr_word;
         default:                                rdata_next = low_power_pkg::ZERO_WORD;
      endcase
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_reg <= low_power_pkg::ZERO_WORD;
      end else begin
         rdata_reg <= read_i ? rdata_next : low_power_pkg::ZERO_WORD;
      end
   end

   // ----------------------------------------------------------------
   // clocks and phy
   // ----------------------------------------------------------------
   // index 0 core, 1 receive, 2 transmit
   logic [2:0] gated;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_gate
         clock_gate #(.DIV(CLOCK_DIV)) u_gate (
            .clock_i       (clock_i),
            .reset_i       (reset_i),
            .enable_i      (core_power_enable),
            .gated_clock_o (gated[g]),
            .running_o     (clocks_running[g])
         );
      end
   endgenerate

   assign pwr.power_down    = phy_power_down_reg;
   assign pwr.isolate_clear = isolate_clear_reg;

   phy_power #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_phy (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .pwr     (pwr.phy)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata_o          = rdata_reg;
   assign tx_active_o      = tx_active_reg;
   assign rx_active_o      = rx_active_reg;
   assign rx_store_o       = rx_store_reg;
   assign mac_core_clock_o = gated[0];
   assign rx_clock_o       = gated[1];
   assign tx_clock_o       = gated[2];
   assign line_oe_n_o      = pwr.line_oe_n;
endmodule : low_power_sequencer

/* testbench/low_power_sequencer_asserts.sv */
// Purpose: port-level checks of the low power sequencer
// Assumes: one clock, enables mirrored from host writes
// Notes:   shadows update on the same edge as the design registers
`timescale 1ns/100ps
module low_power_sequencer_asserts #(
   parameter int CLOCK_DIV = 2
) (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        write_i,
   input wire logic        read_i,
   input wire logic [15:0] rdata_o,
   input wire logic        tx_pending_i,
   input wire logic        tx_done_i,
   input wire logic        rx_end_i,
   input wire logic        tx_active_o,
   input wire logic        rx_active_o,
   input wire logic        rx_store_o,
   input wire logic        mac_core_clock_o,
   input wire logic        rx_clock_o,
   input wire logic        tx_clock_o,
   input wire logic        line_oe_n_o
);
   // ----------------------------------------------------------------
   // shadow state
   // ----------------------------------------------------------------
   logic       cpe_reg;
   logic       tx_en_reg;
   logic       rx_en_reg;
   logic [7:0] off_cnt_reg;
   wire        wr_cfg = write_i && (addr_i == low_power_pkg::CHIP_CONFIGURATION_ADDR);
   wire        wr_tx  = write_i && (addr_i == low_power_pkg::TX_CONTROL_ADDR);
   wire        wr_rx  = write_i && (addr_i == low_power_pkg::RX_CONTROL_ADDR);
   wire        wr_pdn = write_i && (addr_i == low_power_pkg::PHY_CONTROL_ADDR)
                        && wdata_i[low_power_pkg::PHY_POWER_DOWN_BIT];
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         cpe_reg     <= 1'b1;
         tx_en_reg   <= 1'b0;
         rx_en_reg   <= 1'b0;
         off_cnt_reg <= 8'h00;
      end else begin
         if (wr_cfg) cpe_reg <= wdata_i[low_power_pkg::CORE_POWER_ENABLE_BIT];
         if (wr_tx) tx_en_reg <= wdata_i[low_power_pkg::TX_PATH_ENABLE_BIT];
         if (wr_rx) rx_en_reg <= wdata_i[low_power_pkg::RX_PATH_ENABLE_BIT];
         // saturates so a long low power stay never wraps back to zero
         off_cnt_reg <= cpe_reg ? 8'h00 : (off_cnt_reg == 8'hff ? off_cnt_reg : off_cnt_reg + 8'h01);
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_rx_ends;
      rx_active_o && rx_end_i;
   endsequence
   sequence s_store_pulse;
      !rx_active_o && rx_store_o ##1 !rx_store_o;
   endsequence
   chk_rdata_quiet: assert property (!read_i |=> rdata_o == low_power_pkg::ZERO_WORD)
      else $error("read data not zero outside the read answer cycle");
   chk_tx_start_cause: assert property ($rose(tx_active_o) |-> $past(tx_en_reg && tx_pending_i))
      else $error("transmit started without enable and pending frame");
   chk_tx_frame_held: assert property (tx_active_o && !tx_done_i |=> tx_active_o)
      else $error("transmit frame cut short");
   chk_tx_frame_ends: assert property (tx_active_o && tx_done_i |=> !tx_active_o)
      else $error("transmit still active after frame end");
   chk_rx_refused: assert property (!rx_en_reg && !rx_active_o |=> !rx_active_o)
      else $error("frame accepted while receive disabled");
   chk_rx_frame_store: assert property (s_rx_ends |=> s_store_pulse)
      else $error("receive end did not store exactly once");
   chk_line_float: assert property (wr_pdn |-> ##[1:3] line_oe_n_o)
      else $error("line still driven after phy power down");
   chk_gate_off: assert property (off_cnt_reg >= 8'(4 * CLOCK_DIV) |->
                                  !mac_core_clock_o && !rx_clock_o && !tx_clock_o)
      else $error("gated clocks still running in low power");
   chk_gate_on: assert property ($rose(cpe_reg) |-> ##[1:12] mac_core_clock_o)
      else $error("core clock did not return after power enable");
   chk_clock_no_glitch: assert property ($rose(mac_core_clock_o) |-> mac_core_clock_o[*2])
      else $error("short high pulse on core clock");
   chk_tx_clock_low: assert property ($fell(tx_clock_o) |-> !tx_clock_o[*2])
      else $error("short low pulse on transmit clock");
endmodule : low_power_sequencer_asserts
bind low_power_sequencer low_power_sequencer_asserts #(.CLOCK_DIV(CLOCK_DIV)) u_chk (
   .clock_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i, .rdata_o, .tx_pending_i, .tx_done_i,
   .rx_end_i, .tx_active_o, .rx_active_o, .rx_store_o, .mac_core_clock_o, .rx_clock_o, .tx_clock_o,
   .line_oe_n_o);

/* testbench/low_power_sequencer_tb.sv */
// Purpose: directed bench of the low power enter and restore flows
// Assumes: settle count shortened to 20 cycles
// Notes:   the bench plays the host driver and the frame source
`timescale 1ns/100ps
module low_power_sequencer_tb;
   logic        clock_i = 0, reset_i = 1, write_i = 0, read_i = 0;
   logic [3:0]  addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o, d;
   logic        tx_pending_i = 0, tx_done_i = 0, rx_start_i = 0, rx_end_i = 0;
   logic        tx_active_o, rx_active_o, rx_store_o, mac_core_clock_o, rx_clock_o, tx_clock_o, line_oe_n_o;
   int          error_cnt = 0, tests_run = 0;
   always #25 clock_i = ~clock_i;
   low_power_sequencer #(.SETTLE_CYCLES(20)) dut (.clock_i, .reset_i, .addr_i, .wdata_i, .write_i, .read_i,
      .rdata_o, .tx_pending_i, .tx_done_i, .rx_start_i, .rx_end_i, .tx_active_o, .rx_active_o, .rx_store_o,
      .mac_core_clock_o, .rx_clock_o, .tx_clock_o, .line_oe_n_o);
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock_i) begin addr_i <= a; wdata_i <= v; write_i <= 1; end
      @(posedge clock_i) write_i <= 0;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clock_i) begin addr_i <= a; read_i <= 1; end
      @(posedge clock_i) read_i <= 0;
      #1 d = rdata_o;
   endtask : rd
   task pulse(input int sel);
      @(posedge clock_i) if (sel == 0) tx_done_i <= 1; else if (sel == 1) rx_start_i <= 1; else rx_end_i <= 1;
      @(posedge clock_i) begin tx_done_i <= 0; rx_start_i <= 0; rx_end_i <= 0; end
      #1;
   endtask : pulse
   task wait_for(input int sel, input logic lvl);
      int n;
      n = 0;
      while ((sel == 0 ? tx_active_o : sel == 1 ? rx_active_o : sel == 2 ? line_oe_n_o : mac_core_clock_o) !== lvl)
      begin
         @(posedge clock_i) #1 n++;
         if (n > 200) begin
            check("bounded wait", 16'(sel), 16'hffff);
            conclude();
         end
      end
   endtask : wait_for
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset_vals;
      rd(low_power_pkg::CHIP_CONFIGURATION_ADDR); check("config", d, low_power_pkg::CHIP_CONFIGURATION_RESET);
      wr(4'hf, 16'hffff);
      rd(4'hf); check("unmapped", d, 16'h0000);
      rd(low_power_pkg::BUFFER_STATUS_ADDR); check("buffers idle", d, 16'h1c00);
      rd(low_power_pkg::POWER_STATUS_ADDR); check("power idle", d & 16'h007f, 16'h002e);
   endtask : t_reset_vals
   task t_tx;
      wr(low_power_pkg::BUFFER_COMMAND_ADDR, 16'h0001);
      wr(low_power_pkg::TX_CONTROL_ADDR, 16'h0001);
      @(posedge clock_i) tx_pending_i <= 1;
      wait_for(0, 1);
      wr(low_power_pkg::TX_CONTROL_ADDR, 16'h0000);
      repeat (3) @(posedge clock_i);
      #1 check("tx held", 16'(tx_active_o), 16'h0001);
      pulse(0);
      repeat (4) @(posedge clock_i);
      #1 check("tx no restart", 16'(tx_active_o), 16'h0000);
      @(posedge clock_i) tx_pending_i <= 0;
      rd(low_power_pkg::BUFFER_STATUS_ADDR); check("txq filled", 16'(d[10]), 16'h0000);
      wr(low_power_pkg::BUFFER_COMMAND_ADDR, 16'h0002);
      rd(low_power_pkg::BUFFER_STATUS_ADDR); check("txq drained", 16'(d[10]), 16'h0001);
   endtask : t_tx
   task t_rx;
      wr(low_power_pkg::RX_CONTROL_ADDR, 16'h0001);
      pulse(1);
      wait_for(1, 1);
      wr(low_power_pkg::RX_CONTROL_ADDR, 16'h0000);
      #1 check("rx held", 16'(rx_active_o), 16'h0001);
      pulse(2);
      check("rx stored", 16'(rx_store_o), 16'h0001);
      pulse(1);
      repeat (3) @(posedge clock_i);
      #1 check("rx refused", 16'(rx_active_o), 16'h0000);
      rd(low_power_pkg::BUFFER_STATUS_ADDR); check("rx held buffer", d, 16'h0401);
      wr(low_power_pkg::BUFFER_COMMAND_ADDR, 16'h0003);
      rd(low_power_pkg::BUFFER_STATUS_ADDR); check("all free", d, 16'h1c00);
   endtask : t_rx
   task t_power_down;
      rd(low_power_pkg::CHIP_CONFIGURATION_ADDR);
      check("context saved", d, low_power_pkg::CHIP_CONFIGURATION_RESET);
      wr(low_power_pkg::PHY_CONTROL_ADDR, 16'h0800);
      repeat (3) @(posedge clock_i);
      #1 check("line floats", 16'(line_oe_n_o), 16'h0001);
      wr(low_power_pkg::CHIP_CONFIGURATION_ADDR, 16'h0000);
      repeat (12) @(posedge clock_i);
      // every sample over two full divided periods must be low
      repeat (8) @(posedge clock_i) #1 check("gated", 16'({mac_core_clock_o, rx_clock_o, tx_clock_o}), 16'h0000);
      rd(low_power_pkg::CHIP_CONFIGURATION_ADDR); check("config in low power", d, 16'h0000);
      rd(low_power_pkg::POWER_STATUS_ADDR); check("low power status", 16'(d[4:1]), 16'h0008);
      wr(low_power_pkg::TX_CONTROL_ADDR, 16'h0001);
      @(posedge clock_i) tx_pending_i <= 1;
      repeat (6) @(posedge clock_i);
      #1 check("tx while gated", 16'(tx_active_o), 16'h0000);
      @(posedge clock_i) tx_pending_i <= 0;
      wr(low_power_pkg::TX_CONTROL_ADDR, 16'h0000);
   endtask : t_power_down
   task t_restore;
      wr(low_power_pkg::CHIP_CONFIGURATION_ADDR, 16'h8000);
      wait_for(3, 1);
      wr(low_power_pkg::PHY_CONTROL_ADDR, 16'h0000);
      rd(low_power_pkg::PHY_CONTROL_ADDR); check("isolated", 16'(d[10]), 16'h0001);
      wait_for(2, 0);
      wr(low_power_pkg::PHY_CONTROL_ADDR, 16'h0000);
      rd(low_power_pkg::POWER_STATUS_ADDR); check("not settled", 16'(d[7:6]), 16'h0000);
      repeat (25) @(posedge clock_i);
      rd(low_power_pkg::POWER_STATUS_ADDR); check("settled", 16'(d[7:6]), 16'h0002);
      wr(low_power_pkg::BUFFER_COMMAND_ADDR, 16'h0001);
      wr(low_power_pkg::BUFFER_COMMAND_ADDR, 16'h0004);
      rd(low_power_pkg::BUFFER_STATUS_ADDR); check("buffer reset", d, 16'h1c00);
      wr(low_power_pkg::TX_CONTROL_ADDR, 16'h0001);
      @(posedge clock_i) tx_pending_i <= 1;
      wait_for(0, 1);
      @(posedge clock_i) tx_pending_i <= 0;
      pulse(0);
      wr(low_power_pkg::RX_CONTROL_ADDR, 16'h0001);
      pulse(1);
      wait_for(1, 1);
      pulse(2);
      check("rx back", 16'(rx_store_o), 16'h0001);
   endtask : t_restore
   initial begin
      repeat (8) @(posedge clock_i);
      reset_i <= 0;
      t_reset_vals();
      t_tx();
      t_rx();
      t_power_down();
      t_restore();
      conclude();
   end
endmodule : low_power_sequencer_tb
